// *** pdm_params.svh ***
`ifndef PDM_PARAMS_SVH
`define PDM_PARAMS_SVH

// special-function addresses
`define PDM_ADDR_P2_DRIVE   8'hA6
`define PDM_ADDR_P3_LATCH   8'hB0
// page that holds the port 2 drive-style register
`define PDM_PAGE_F          8'h0F
// reset values
`define PDM_RST_P2_DRIVE    8'h00
`define PDM_RST_P3_LATCH    8'hFF
// bit-address base of the port 3 latch (bit address = base + bit)
`define PDM_BITBASE_P3      8'hB0
// external memory mode encodings
`define PDM_EMIF_OFF        2'h0
`define PDM_EMIF_MUX        2'h1
`define PDM_EMIF_NONMUX     2'h2

`endif

// *** pdm_pkg.sv ***
package pdm_pkg;

  // one special-function register access from the core
  typedef struct packed {
    logic       byte_wr;
    logic       bit_wr;
    logic       rd;
    logic       rmw;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wbit;
    logic [7:0] page;
  } pdm_sfr_req_t;

  // external memory takeover of the port 3 pins
  typedef struct packed {
    logic [1:0] mode;
    logic       drive;
    logic [7:0] data;
  } pdm_emif_t;

  // pin driver bundle
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pdm_pins_t;

endpackage

// *** pdm_port_data.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "pdm_params.svh"

module pdm_port_data
  import pdm_pkg::*;
(
  // clock and reset
  input  wire  logic         sys_clk,
  input  wire  logic         rst,
  // core register access
  input  wire  pdm_sfr_req_t req,
  output var   logic [7:0]   rdata,
  output var   logic         rvalid,
  // external memory takeover
  input  wire  pdm_emif_t    emif,
  // port 3 drive style from its own register
  input  wire  logic [7:0]   p3_drive_style,
  // port 2 latch value owned elsewhere
  input  wire  logic [7:0]   p2_latch,
  // pins
  input  wire  logic [7:0]   p2_pin_in,
  input  wire  logic [7:0]   p3_pin_in,
  output var   pdm_pins_t    p2_pins,
  output var   pdm_pins_t    p3_pins
);

  // ----------------------------------------
  // internal signals
  // ----------------------------------------
  logic [7:0] p2_s1_q;
  logic [7:0] p2_s2_q;
  logic [7:0] p3_s1_q;
  logic [7:0] p3_s2_q;
  wire        unused_p2;
  wire  [7:0] p3_bit_base;
  wire        on_page_f;
  wire        hit_p2_drive;
  wire        hit_p3_byte;
  wire        hit_p3_bit;
  wire  [2:0] bit_idx;
  wire        wr_p2_drive;
  wire        wr_p3_byte;
  wire        wr_p3_bit;
  logic [7:0] p2_drive_q;
  wire  [7:0] p2_drive_d;
  logic [7:0] p3_latch_q;
  wire  [7:0] p3_latch_d;
  wire        emif_on;
  wire        emif_own;
  wire  [7:0] p3_val;
  wire  [7:0] p3_oe;
  wire  [7:0] p2_oe;
  wire  [7:0] p3_rd_src;
  wire  [7:0] rd_mux;
  wire  [7:0] rdata_d;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // only the second stage is read, keeping metastability out of the read mux
  always_ff @(posedge sys_clk) begin
    p2_s1_q <= p2_pin_in;
    p2_s2_q <= p2_s1_q;
  end

  always_ff @(posedge sys_clk) begin
    p3_s1_q <= p3_pin_in;
    p3_s2_q <= p3_s1_q;
  end

  // port 2 pin reads belong to the port 2 data register kept elsewhere
  assign unused_p2 = ^p2_s2_q;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // replace one bit of a byte, leaving the others as they were
  function automatic logic [7:0] bit_set(input logic [7:0] v, input logic [2:0] idx, input logic b);
    logic [7:0] r;
    r = v;
    r[idx] = b;
    return r;
  endfunction

  // move one bit of a byte to bit 0, where a bit read returns it
  function automatic logic [7:0] bit_get(input logic [7:0] v, input logic [2:0] idx);
    logic [7:0] r;
    r    = 8'h00;
    r[0] = v[idx];
    return r;
  endfunction

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // bit addresses share their top five bits with the latch's byte address
  assign p3_bit_base  = `PDM_BITBASE_P3;
  assign on_page_f    = (req.page == `PDM_PAGE_F);
  assign hit_p2_drive = (req.addr == `PDM_ADDR_P2_DRIVE) && on_page_f;
  assign hit_p3_byte  = (req.addr == `PDM_ADDR_P3_LATCH);
  assign hit_p3_bit   = (req.addr[7:3] == p3_bit_base[7:3]);
  assign bit_idx      = req.addr[2:0];

  // ----------------------------------------
  // write strobes
  // ----------------------------------------
  assign wr_p2_drive  = req.byte_wr && hit_p2_drive;
  assign wr_p3_byte   = req.byte_wr && hit_p3_byte;
  assign wr_p3_bit    = req.bit_wr && hit_p3_bit;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // a byte write to the latch wins over a bit write in the same cycle
  assign p2_drive_d   = wr_p2_drive ? req.wdata : p2_drive_q;
  assign p3_latch_d   = wr_p3_byte ? req.wdata :
                        wr_p3_bit  ? bit_set(p3_latch_q, bit_idx, req.wbit) :
                        p3_latch_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p2_drive_q <= `PDM_RST_P2_DRIVE;
    end else begin
      p2_drive_q <= p2_drive_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p3_latch_q <= `PDM_RST_P3_LATCH;
    end else begin
      p3_latch_q <= p3_latch_d;
    end
  end

  // ----------------------------------------
  // port 3 pin drive
  // ----------------------------------------
  // external memory owns the pins outright while it drives them
  assign emif_on  = (emif.mode == `PDM_EMIF_MUX) || (emif.mode == `PDM_EMIF_NONMUX);
  assign emif_own = emif_on && emif.drive;
  assign p3_val   = emif_own ? emif.data : p3_latch_q;
  // open-drain releases on 1: only push-pull, or external memory while it drives the pins, actively drives high
  assign p3_oe    = emif_own ? 8'hFF : (~p3_val | p3_drive_style);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p3_pins <= '0;
    end else begin
      p3_pins.out <= p3_val;
      p3_pins.oe  <= p3_oe;
    end
  end

  // ----------------------------------------
  // port 2 pin drive
  // ----------------------------------------
  // the port 2 latch lives elsewhere; only its drive style is kept here
  assign p2_oe    = ~p2_latch | p2_drive_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p2_pins <= '0;
    end else begin
      p2_pins.out <= p2_latch;
      p2_pins.oe  <= p2_oe;
    end
  end

  // ----------------------------------------
  // read select
  // ----------------------------------------
  // pin level reaches the read two edges after the pin moves, hence the fast-clock caveat
  // the read phase of a read-modify-write sees the latch, so unread pins cannot corrupt it
  assign p3_rd_src = req.rmw ? p3_latch_q : p3_s2_q;
  assign rd_mux    = hit_p2_drive ? p2_drive_q :
                     hit_p3_byte  ? p3_rd_src :
                     hit_p3_bit   ? bit_get(p3_rd_src, bit_idx) :
                     8'h00;
  // reads outside this block's addresses answer with zero
  assign rdata_d   = req.rd ? rd_mux : 8'h00;

  // ----------------------------------------
  // read answer
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
    end
  end

endmodule

`default_nettype wire

// *** pdm_pin_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pdm_pin_model
  import pdm_pkg::*;
(
  input  wire pdm_pins_t  pins,
  input  wire logic [7:0] ext,
  output wire logic [7:0] pin
);
  // a released pin shows the board level, never the last value driven
  assign pin = (pins.oe & pins.out) | (~pins.oe & ext);
endmodule
`default_nettype wire

// *** pdm_port_data_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module pdm_port_data_chk
  import pdm_pkg::*;
(
  input wire logic         sys_clk, rst, rvalid,
  input wire pdm_sfr_req_t req,
  input wire logic [7:0]   rdata, p3_drive_style, p2_latch, p2_pin_in, p3_pin_in,
  input wire pdm_emif_t    emif,
  input wire pdm_pins_t    p2_pins, p3_pins
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (rvalid == $past(req.rd)) else $error("rvalid");
  a_p3_drive: assert property (!rst && !((emif.mode == 2'h1 || emif.mode == 2'h2) && emif.drive)
    |=> (p3_pins.oe | p3_pins.out) == 8'hFF
    && (p3_pins.oe & p3_pins.out & ~$past(p3_drive_style)) == 8'h00) else $error("p3 drive");
  a_emif_take: assert property (!rst && (emif.mode == 2'h1 || emif.mode == 2'h2) && emif.drive
    |=> p3_pins.oe == 8'hFF && p3_pins.out == $past(emif.data)) else $error("emif");
  a_p2_low: assert property (!rst |=> (~$past(p2_latch) & ~(p2_pins.oe & ~p2_pins.out)) == 8'h00)
    else $error("p2 low");
  a_p2_page: assert property (req.byte_wr && req.addr == 8'hA6 && req.page != 8'h0F |-> ##2 $stable(p2_pins.oe))
    else $error("p2 page");
  a_p2_write: assert property (req.byte_wr && req.addr == 8'hA6 && req.page == 8'h0F
    |-> ##2 p2_pins.oe == (~p2_latch | $past(req.wdata, 2))) else $error("p2 style");
  a_unmapped_zero: assert property (req.rd && req.addr == 8'hC3 |=> rdata == 8'h00) else $error("unmapped");
  a_pin_read: assert property (req.rd && !req.rmw && req.addr == 8'hB0 && p3_pin_in == $past(p3_pin_in)
    && p3_pin_in == $past(p3_pin_in, 2) |=> rdata == $past(p3_pin_in)) else $error("pin read");
endmodule
bind pdm_port_data pdm_port_data_chk u_chk (.*);
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pdm_pkg::*;
  logic sys_clk = 0, rst = 1, rvalid;
  logic [7:0] rdata, p3_drive_style = 8'h00, p2_latch = 8'h5A, p2_pin_in, p3_pin_in, e2 = 8'hC3, e3, l, v;
  logic [31:0] s = 33;
  int num_errors = 0, n_tests = 0, cyc = 0;
  pdm_sfr_req_t req = '0;
  pdm_emif_t emif = '0;
  pdm_pins_t p2_pins, p3_pins;
  logic [7:0] q[$];
  pdm_port_data u_pdm_port_data (.*);
  pdm_pin_model u_p2 (.pins(p2_pins), .ext(e2), .pin(p2_pin_in));
  pdm_pin_model u_p3 (.pins(p3_pins), .ext(e3), .pin(p3_pin_in));
  initial forever #4 sys_clk = ~sys_clk;
  function automatic logic [7:0] rnd;
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction
  task automatic chk(logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %0t %h %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("errors %0d tests %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic acc(logic w, b, r, m, logic [7:0] a, d, pg);
    req = '{w, b, r, m, a, d, d[0], pg};
    @(negedge sys_clk);
    req = '0;
    repeat (6) @(negedge sys_clk);
  endtask
  task automatic rd(logic [7:0] a, logic m, logic [7:0] e);
    q.push_back(e);
    acc(0, 0, 1, m, a, 8'h00, 8'h0F);
  endtask
  always @(negedge sys_clk) begin
    cyc++;
    if (cyc > 3000) begin
      num_errors++;
      give_verdict();
    end
    if (rvalid === 1'b1) chk(rdata, q.pop_front());
  end
  initial begin
    e3 = rnd();
    repeat (12) @(negedge sys_clk);
    rst = 0;
    rd(8'hB0, 1, 8'hFF);
    rd(8'hA6, 0, 8'h00);
    l = rnd();
    acc(1, 0, 0, 0, 8'hB0, l, rnd());
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      l[i] = v[0];
      acc(0, 1, 0, 0, 8'hB0 + i[7:0], v, 8'h00);
    end
    rd(8'hB0, 1, l);
    rd(8'hB3, 1, {7'h00, l[3]});
    rd(8'hB0, 0, l & e3);
    p3_drive_style = 8'hFF;
    repeat (4) @(negedge sys_clk);
    rd(8'hB0, 0, l);
    rd(8'hB5, 0, {7'h00, l[5]});
    v = rnd();
    acc(1, 0, 0, 0, 8'hA6, v, 8'h00);
    rd(8'hA6, 0, 8'h00);
    acc(1, 0, 0, 0, 8'hA6, v, 8'h0F);
    rd(8'hA6, 0, v);
    rd(8'hC3, 0, 8'h00);
    for (int m = 1; m < 3; m++) begin
      emif = '{m[1:0], 1'b1, ~l};
      repeat (4) @(negedge sys_clk);
      rd(8'hB0, 0, ~l);
    end
    emif = '0;
    give_verdict();
  end
endmodule
`default_nettype wire
